// File: ebsr_ctrl.v
`timescale 1ns/10ps
`include "ebsr_defines.vh"
module ebsr_ctrl (
    // clock and reset
    input  wire        clk_i,
    input  wire        arst_n_i,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // core status inputs
    input  wire        watchdog_timer_timeout_i,
    input  wire        xdata_access_i,
    input  wire        table_move_i,
    input  wire        lock_bit1_i,
    input  wire        flash_program_pulse_input_i,
    // core serial, write and read strobes for port 3
    input  wire        serial_tx_i,
    input  wire        xdata_wr_n_i,
    input  wire        xdata_rd_n_i,
    // reset pin
    input  wire        reset_pin_i,
    output reg         reset_pin_o,
    output wire        reset_pin_oe_o,
    output reg         core_reset_o,
    // address latch / programming pulse pin
    input  wire        ale_pin_i,
    output reg         ale_pin_o,
    output reg         ale_pin_oe_o,
    output reg         ale_weak_pullup_o,
    output wire        program_pulse_input_o,
    // program store read strobe
    output reg         program_store_read_strobe_n_o,
    // external access select
    input  wire        external_access_select_n_i,
    output wire        code_external_o,
    // port 3
    input  wire [7:0]  p3_pin_i,
    output wire [7:0]  p3_o,
    output wire [7:0]  p3_oe_o,
    output wire        serial_rx_o,
    output wire        external_interrupt_zero_n_o,
    output wire        external_interrupt_one_n_o,
    output wire        timer_zero_count_input_o,
    output wire        timer_one_count_input_o
);
    // ------------------------------------------------
    // machine cycle timing
    // ------------------------------------------------
    wire [3:0] phase;
    wire       mc_end;
    ebsr_mc_timer u_mc (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .phase_o  (phase),
        .mc_end_o (mc_end)
    );

    function in_window;
        input [3:0] ph;
        input [3:0] start;
        input [3:0] width;
        begin
            in_window = (ph >= start) && (ph < start + width);
        end
    endfunction

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    reg  [7:0] aux_q;
    reg  [7:0] p3_q;
    reg        ea_latched_q;
    reg        ea_caught_q;
    reg        first_clk_q;
    wire       ale_dis  = aux_q[`EBSR_AUX_ALE_DIS];
    wire       rto_dis  = aux_q[`EBSR_AUX_RTO_DIS];

    // ------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------
    reg  [11:0] awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         aw_have_q;
    reg         w_have_q;
    wire        wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    wire        wr_aux  = wr_fire && (awaddr_q[11:2] == `EBSR_ADDR_AUX >> 2) && wstrb_q[0];
    wire        wr_p3   = wr_fire && (awaddr_q[11:2] == `EBSR_ADDR_P3 >> 2) && wstrb_q[0];
    wire        wr_ok   = (awaddr_q[11:2] == `EBSR_ADDR_AUX >> 2) ||
                          (awaddr_q[11:2] == `EBSR_ADDR_P3 >> 2);

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            awaddr_q     <= 12'h000;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EBSR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q  <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `EBSR_RESP_OKAY : `EBSR_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire [31:0] status_word = {26'h0, ale_pin_o, program_store_read_strobe_n_o,
                               reset_pin_o, core_reset_o, ea_latched_q, code_external_o};

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `EBSR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `EBSR_RESP_OKAY;
            case (s_axi_araddr[11:2])
                `EBSR_ADDR_AUX >> 2:    s_axi_rdata <= {24'h0, aux_q};
                `EBSR_ADDR_STATUS >> 2: s_axi_rdata <= status_word;
                `EBSR_ADDR_P3 >> 2:     s_axi_rdata <= {24'h0, p3_q};
                `EBSR_ADDR_P3PIN >> 2:  s_axi_rdata <= {24'h0, p3_pin_i};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `EBSR_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aux_q <= `EBSR_AUX_RESET;
            p3_q  <= `EBSR_P3_RESET;
        end else begin
            if (wr_aux) begin
                aux_q <= wdata_q[7:0] & `EBSR_AUX_MASK;
            end
            if (wr_p3) begin
                p3_q <= wdata_q[7:0];
            end
        end
    end

    // ------------------------------------------------
    // reset input detect and reset-out drive
    // ------------------------------------------------
    reg [1:0] rst_mc_q;
    reg [3:0] rst_ph_q;
    reg [6:0] rto_cnt_q;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_mc_q     <= 2'd0;
            rst_ph_q     <= 4'h0;
            core_reset_o <= 1'b1;
        end else if (!reset_pin_i || reset_pin_o) begin
            rst_mc_q     <= 2'd0;
            rst_ph_q     <= 4'h0;
            core_reset_o <= reset_pin_o;
        end else if (rst_mc_q == `EBSR_RST_MC) begin
            core_reset_o <= 1'b1;
        end else if (rst_ph_q == `EBSR_MC_LAST) begin
            rst_ph_q <= 4'h0;
            rst_mc_q <= rst_mc_q + 2'd1;
        end else begin
            rst_ph_q <= rst_ph_q + 4'h1;
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rto_cnt_q   <= 7'd0;
            reset_pin_o <= 1'b0;
        end else if (watchdog_timer_timeout_i && !rto_dis && !reset_pin_o) begin
            rto_cnt_q   <= `EBSR_RSTOUT_PER - 7'd1;
            reset_pin_o <= 1'b1;
        end else if (reset_pin_o) begin
            if (rto_cnt_q == 7'd0) begin
                reset_pin_o <= 1'b0;
            end else begin
                rto_cnt_q <= rto_cnt_q - 7'd1;
            end
        end
    end
    assign reset_pin_oe_o = reset_pin_o;

    // ------------------------------------------------
    // external access select capture
    // ------------------------------------------------
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ea_latched_q <= 1'b0;
            ea_caught_q  <= 1'b0;
            first_clk_q  <= 1'b1;
        end else begin
            first_clk_q <= 1'b0;
            if (core_reset_o || first_clk_q) begin
                ea_latched_q <= external_access_select_n_i;
                ea_caught_q  <= 1'b1;
            end
        end
    end
    assign code_external_o = lock_bit1_i && ea_caught_q ? !ea_latched_q
                                                          : !external_access_select_n_i;

    // ------------------------------------------------
    // address latch and program store strobe
    // ------------------------------------------------
    reg  xd_q;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            xd_q <= 1'b0;
        end else if (mc_end) begin
            xd_q <= xdata_access_i;
        end
    end

    // pulses start only at a window's first phase, then run full width: no runt strobes
    wire ale_on     = !ale_dis || code_external_o || table_move_i || xd_q;
    wire ale_start  = ((phase == `EBSR_ALE_PH0) || ((phase == `EBSR_ALE_PH1) && !xd_q)) &&
                      ale_on;
    wire ale_hold   = ale_pin_o && (in_window(phase, `EBSR_ALE_PH0, `EBSR_ALE_WIDTH) ||
                                    in_window(phase, `EBSR_ALE_PH1, `EBSR_ALE_WIDTH));
    wire ale_drive  = ale_on || ale_hold;
    wire program_store_read_strobe_start = ((phase == `EBSR_PROGRAM_STORE_READ_STROBE_PH0) || (phase == `EBSR_PROGRAM_STORE_READ_STROBE_PH1)) &&
                      code_external_o && !xd_q;
    wire program_store_read_strobe_hold  = !program_store_read_strobe_n_o &&
                      (in_window(phase, `EBSR_PROGRAM_STORE_READ_STROBE_PH0, `EBSR_PROGRAM_STORE_READ_STROBE_WIDTH) ||
                       in_window(phase, `EBSR_PROGRAM_STORE_READ_STROBE_PH1, `EBSR_PROGRAM_STORE_READ_STROBE_WIDTH));

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ale_pin_o                     <= 1'b0;
            ale_pin_oe_o                  <= 1'b0;
            ale_weak_pullup_o             <= 1'b1;
            program_store_read_strobe_n_o <= 1'b1;
        end else if (flash_program_pulse_input_i || core_reset_o) begin
            ale_pin_o                     <= 1'b0;
            ale_pin_oe_o                  <= 1'b0;
            ale_weak_pullup_o             <= 1'b1;
            program_store_read_strobe_n_o <= 1'b1;
        end else begin
            ale_pin_o                     <= ale_start || ale_hold;
            ale_pin_oe_o                  <= ale_drive;
            ale_weak_pullup_o             <= !ale_drive;
            program_store_read_strobe_n_o <= !(program_store_read_strobe_start || program_store_read_strobe_hold);
        end
    end
    assign program_pulse_input_o = flash_program_pulse_input_i && !ale_pin_i;

    // ------------------------------------------------
    // port 3 alternate functions
    // ------------------------------------------------
    wire [7:0] p3_alt = {xdata_rd_n_i, xdata_wr_n_i, 4'hf, serial_tx_i, 1'b1};
    wire [7:0] p3_lvl = p3_q & p3_alt;
    assign p3_o    = p3_lvl;
    assign p3_oe_o = ~p3_lvl;
    assign serial_rx_o                 = p3_pin_i[0];
    assign external_interrupt_zero_n_o = p3_pin_i[2];
    assign external_interrupt_one_n_o  = p3_pin_i[3];
    assign timer_zero_count_input_o    = p3_pin_i[4];
    assign timer_one_count_input_o     = p3_pin_i[5];
endmodule

// File: ebsr_defines.vh
// How it works
// - reset input high for two machine cycles resets the device; source holds it that long
// - after watchdog timeout the reset pin is driven high for 98 oscillator periods
// - reset-out disable bit in auxiliary control suppresses reset drive; default enabled
// - address latch pulse lets outside logic capture the low address byte
// - normally the address latch pulse runs continuously at one sixth of oscillator
// - each external data access omits exactly one address latch pulse
// - bit 0 of auxiliary control limits latch pulses to data move and table reads
// - latch pin weakly pulled high when disabled and no qualifying instruction runs
// - in external execution the latch disable bit has no effect
// - external code fetch asserts program-store read strobe twice per machine cycle
// - each external data access omits two program-store read strobe activations
// - external access select tied low fetches all code externally, 0000H to FFFFH
// - with lock bit 1 programmed, external access select is latched at reset
// - latch pin serves as programming pulse input during flash programming
// - port 3 pins written with ones are pulled high and usable as inputs
// - port 3 bit 0 is serial receive, bit 1 serial transmit
// - port 3 bits 2,3 external interrupts; bits 4,5 timer count inputs
// - port 3 bit 6 data write strobe, bit 7 data read strobe
`ifndef EBSR_DEFINES_VH
`define EBSR_DEFINES_VH
`define EBSR_MC_LEN        4'd12
`define EBSR_MC_LAST       4'hb
`define EBSR_ALE_PH0       4'h0
`define EBSR_ALE_PH1       4'h6
`define EBSR_ALE_WIDTH     4'h2
`define EBSR_PROGRAM_STORE_READ_STROBE_PH0      4'h3
`define EBSR_PROGRAM_STORE_READ_STROBE_PH1      4'h9
`define EBSR_PROGRAM_STORE_READ_STROBE_WIDTH    4'h3
`define EBSR_RST_MC        2'd2
`define EBSR_RSTOUT_PER    7'd98
`define EBSR_AUX_OFFSET    8'h8e
`define EBSR_AUX_RESET     8'h00
`define EBSR_AUX_MASK      8'h19
`define EBSR_AUX_ALE_DIS   0
`define EBSR_AUX_RTO_DIS   3
`define EBSR_AUX_WDIDLE    4
// byte address is four times the register index
`define EBSR_ADDR_AUX      12'h238
`define EBSR_ADDR_STATUS   12'h004
`define EBSR_ADDR_P3       12'h008
`define EBSR_ADDR_P3PIN    12'h00c
`define EBSR_P3_RESET      8'hff
`define EBSR_RESP_OKAY     2'b00
`define EBSR_RESP_SLVERR   2'b10
`endif

// File: ebsr_mc_timer.v
`timescale 1ns/10ps
`include "ebsr_defines.vh"
// machine cycle phase counter
module ebsr_mc_timer (
    // clock and reset
    input  wire       clk_i,
    input  wire       arst_n_i,
    // phase
    output reg  [3:0] phase_o,
    output wire       mc_end_o
);
    assign mc_end_o = (phase_o == `EBSR_MC_LAST);
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_o <= 4'h0;
        end else if (mc_end_o) begin
            phase_o <= 4'h0;
        end else begin
            phase_o <= phase_o + 4'h1;
        end
    end
endmodule

// File: ebsr_ctrl_sva.sv
`timescale 1ns/10ps
// --------------------------------
// pin timing checker
// --------------------------------
module ebsr_ctrl_sva (
    input wire logic       clk_i, arst_n_i, watchdog_timer_timeout_i, flash_program_pulse_input_i,
    input wire logic       serial_tx_i, xdata_rd_n_i, reset_pin_i, reset_pin_o,
    input wire logic       reset_pin_oe_o, core_reset_o, ale_pin_i, ale_pin_o,
    input wire logic       ale_pin_oe_o, ale_weak_pullup_o, program_pulse_input_o,
    input wire logic       program_store_read_strobe_n_o, code_external_o, serial_rx_o,
    input wire logic       external_interrupt_zero_n_o, external_interrupt_one_n_o,
    input wire logic       timer_zero_count_input_o, timer_one_count_input_o,
    input wire logic [7:0] p3_pin_i, p3_o, p3_oe_o
);
    logic [6:0] ro_q;
    logic [4:0] ri_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // run lengths of reset-out drive and reset pin level
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ro_q <= 7'h00;
            ri_q <= 5'h00;
        end else begin
            ro_q <= reset_pin_o ? ro_q + 7'h01 : 7'h00;
            ri_q <= !reset_pin_i ? 5'h00 : (ri_q == 5'h1f ? ri_q : ri_q + 5'h01);
        end
    end
    // no pulse timing is promised while held in reset or programming
    property p_ale_width;
        disable iff (!arst_n_i || core_reset_o || flash_program_pulse_input_i)
        $rose(ale_pin_o) |-> ale_pin_o [*2] ##1 !ale_pin_o;
    endproperty
    a_ale_width: assert property (p_ale_width) else $error("latch pulse width wrong");
    property p_ale_gap;
        disable iff (!arst_n_i || core_reset_o || flash_program_pulse_input_i)
        $fell(ale_pin_o) |-> !ale_pin_o [*4];
    endproperty
    a_ale_gap: assert property (p_ale_gap) else $error("latch pulse gap short");
    property p_program_store_read_strobe_width;
        disable iff (!arst_n_i || core_reset_o || flash_program_pulse_input_i)
        $fell(program_store_read_strobe_n_o) |-> !program_store_read_strobe_n_o [*3] ##1 program_store_read_strobe_n_o;
    endproperty
    a_program_store_read_strobe_width: assert property (p_program_store_read_strobe_width) else $error("read strobe width wrong");
    property p_program_store_read_strobe_src;
        $fell(program_store_read_strobe_n_o) |-> $past(code_external_o);
    endproperty
    a_program_store_read_strobe_src: assert property (p_program_store_read_strobe_src) else $error("read strobe without external code");
    property p_rst_len;
        $fell(reset_pin_o) |-> ro_q == 7'd98;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset-out length wrong");
    property p_rst_cause;
        $rose(reset_pin_o) |-> $past(watchdog_timer_timeout_i) && reset_pin_oe_o;
    endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("reset-out without timeout");
    property p_core_rst;
        ri_q >= 5'd26 |-> core_reset_o;
    endproperty
    a_core_rst: assert property (p_core_rst) else $error("long reset pin ignored");
    property p_pullup;
        !ale_pin_oe_o |-> ale_weak_pullup_o;
    endproperty
    a_pullup: assert property (p_pullup) else $error("latch pin floating");
    property p_program_pulse_input;
        program_pulse_input_o == (flash_program_pulse_input_i && !ale_pin_i);
    endproperty
    a_program_pulse_input: assert property (p_program_pulse_input) else $error("program pulse wrong");
    property p_p3_oe;
        p3_oe_o == ~p3_o;
    endproperty
    a_p3_oe: assert property (p_p3_oe) else $error("port drive enable wrong");
    property p_p3_ser;
        serial_rx_o == p3_pin_i[0] && (serial_tx_i || !p3_o[1]) && (xdata_rd_n_i || !p3_o[7]);
    endproperty
    a_p3_ser: assert property (p_p3_ser) else $error("serial or strobe route wrong");
    property p_p3_alt;
        {timer_one_count_input_o, timer_zero_count_input_o, external_interrupt_one_n_o,
         external_interrupt_zero_n_o} == p3_pin_i[5:2];
    endproperty
    a_p3_alt: assert property (p_p3_alt) else $error("port input route wrong");
endmodule

// File: ebsr_board_model.sv
`timescale 1ns/10ps
// --------------------------------
// board pins and pull-ups
// --------------------------------
module ebsr_board_model (
    input  wire logic       rst_src_i, ea_ext_i, ale_o_i, ale_oe_i, rst_o_i, rst_oe_i, program_pulse_input_i,
    input  wire logic [7:0] p3_o_i, p3_oe_i, p3_low_i,
    output wire logic       rst_lvl_o, ea_n_o, ale_lvl_o,
    output wire logic [7:0] p3_lvl_o
);
    assign rst_lvl_o = rst_oe_i ? rst_o_i : rst_src_i;
    assign ea_n_o = !ea_ext_i;
    assign ale_lvl_o = ale_oe_i ? ale_o_i : !program_pulse_input_i;
    assign p3_lvl_o = (p3_oe_i & p3_o_i) | (~p3_oe_i & ~p3_low_i);
endmodule

// File: tb_ext_bus_strobe_reset_ctrl.sv
`timescale 1ns/10ps
`include "ebsr_defines.vh"
// --------------------------------
// testbench
// --------------------------------
module tb_ext_bus_strobe_reset_ctrl;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, clk_i, arst_n_i;
    logic        watchdog_timer_timeout_i, xdata_access_i, table_move_i, lock_bit1_i, flash_program_pulse_input_i;
    logic        serial_tx_i, xdata_wr_n_i, xdata_rd_n_i, reset_pin_i, reset_pin_o, reset_pin_oe_o;
    logic        core_reset_o, ale_pin_i, ale_pin_o, ale_pin_oe_o, ale_weak_pullup_o, program_pulse_input_o;
    logic        program_store_read_strobe_n_o, external_access_select_n_i, code_external_o, serial_rx_o;
    logic        external_interrupt_zero_n_o, external_interrupt_one_n_o, rst_src, ea_ext, pa, pp, pg;
    logic        timer_zero_count_input_o, timer_one_count_input_o;
    logic [7:0]  p3_pin_i, p3_o, p3_oe_o, p3_low;
    int          err_count, checks_done, cyc, na, np, nr;
    ebsr_ctrl dut_u (.*);
    ebsr_board_model brd_u (.rst_src_i(rst_src), .ea_ext_i(ea_ext), .ale_o_i(ale_pin_o), .ale_oe_i(ale_pin_oe_o),
        .rst_o_i(reset_pin_o), .rst_oe_i(reset_pin_oe_o), .program_pulse_input_i(pg), .p3_o_i(p3_o), .p3_oe_i(p3_oe_o),
        .p3_low_i(p3_low),
        .rst_lvl_o(reset_pin_i), .ea_n_o(external_access_select_n_i), .ale_lvl_o(ale_pin_i), .p3_lvl_o(p3_pin_i));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic dn;
        dn = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1;
        while (!dn) begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                dn = 1;
                chk(s_axi_bresp, er);
            end
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic dn;
        dn = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        while (!dn) begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                dn = 1;
                chk(s_axi_rdata, ed);
                chk(s_axi_rresp, er);
            end
        end
    endtask
    // counts latch rises, strobe falls and reset-out cycles
    task cnt(input int n, input int xd);
        na = 0;
        np = 0;
        nr = 0;
        pa = ale_pin_o;
        pp = program_store_read_strobe_n_o;
        for (int i = 0; i < n; i++) begin
            xdata_access_i <= (i < xd);
            @(posedge clk_i);
            if (ale_pin_o && !pa) na++;
            if (!program_store_read_strobe_n_o && pp) np++;
            if (reset_pin_o) nr++;
            pa = ale_pin_o;
            pp = program_store_read_strobe_n_o;
        end
    endtask
    task wdog;
        watchdog_timer_timeout_i <= 1;
        @(posedge clk_i);
        watchdog_timer_timeout_i <= 0;
        cnt(120, 0);
    endtask
    initial begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict;
        end
    end
    initial begin
        {arst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, watchdog_timer_timeout_i} = 0;
        {xdata_access_i, table_move_i, lock_bit1_i, flash_program_pulse_input_i, rst_src, ea_ext, pg} = 0;
        {serial_tx_i, xdata_wr_n_i, xdata_rd_n_i, s_axi_bready, s_axi_rready} = 5'h1f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, p3_low} = 0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1;
        @(posedge clk_i);
        rd(`EBSR_ADDR_AUX, 0, 0);
        rd(`EBSR_ADDR_P3, 32'hff, 0);
        rd(12'h100, 0, 2);
        wr(12'h100, 1, 2);
        cnt(60, 0);
        chk(na, 10);
        chk(np, 0);
        ea_ext <= 1;
        cnt(66, 0);
        chk(np, 10);
        cnt(60, 12);
        chk(na, 9);
        chk(np, 8);
        wr(`EBSR_ADDR_AUX, 1, 0);
        cnt(60, 0);
        chk(na, 10);
        ea_ext <= 0;
        @(posedge clk_i);
        cnt(66, 0);
        chk(na, 0);
        chk(ale_pin_i, 1);
        chk(ale_weak_pullup_o, 1);
        table_move_i <= 1;
        cnt(66, 0);
        chk(na, 11);
        table_move_i <= 0;
        wr(`EBSR_ADDR_AUX, 0, 0);
        wdog;
        chk(nr, 98);
        wr(`EBSR_ADDR_AUX, 8, 0);
        rd(`EBSR_ADDR_AUX, 8, 0);
        wdog;
        chk(nr, 0);
        {serial_tx_i, xdata_wr_n_i, xdata_rd_n_i} <= 0;
        p3_low <= 8'h10;
        wr(`EBSR_ADDR_P3, 32'hff, 0);
        rd(`EBSR_ADDR_P3PIN, 32'h2d, 0);
        chk(p3_o, 8'h3d);
        chk(timer_zero_count_input_o, 0);
        {serial_tx_i, xdata_wr_n_i, xdata_rd_n_i, flash_program_pulse_input_i, pg} <= 5'h1f;
        p3_low <= 0;
        rst_src <= 1;
        repeat (10) @(posedge clk_i);
        chk(ale_pin_oe_o, 0);
        chk(program_pulse_input_o, 1);
        {rst_src, flash_program_pulse_input_i, pg} <= 0;
        @(posedge clk_i);
        chk(core_reset_o, 0);
        lock_bit1_i <= 1;
        rst_src <= 1;
        repeat (30) @(posedge clk_i);
        chk(core_reset_o, 1);
        rst_src <= 0;
        repeat (4) @(posedge clk_i);
        ea_ext <= 1;
        repeat (2) @(posedge clk_i);
        chk(code_external_o, 0);
        lock_bit1_i <= 0;
        @(posedge clk_i);
        chk(code_external_o, 1);
        give_verdict;
    end
endmodule
bind ebsr_ctrl ebsr_ctrl_sva chk_u (.*);
